/* hdl/opr_cfg.svh */
/*
  Offsets, field positions, reset values and timing figures of the
  oscillator configuration and power-on reset sequencer.
  Assumes inclusion by bare name, before the package and the module.
*/
`ifndef OPR_CFG_SVH
`define OPR_CFG_SVH
// byte offsets of the bus registers
`define OPR_ADR_TUNE 8'h00
`define OPR_ADR_CFG 8'h04
`define OPR_ADR_CTRL 8'h08
`define OPR_ADR_STAT 8'h0c
`define OPR_ADR_MASK 8'h10
// tuning register
`define OPR_TUNE_W 4
`define OPR_TUNE_RST 4'h0
// configuration word fields
`define OPR_CF_SWM_HI 15
`define OPR_CF_SWM_LO 14
`define OPR_CF_GRP_HI 10
`define OPR_CF_GRP_LO 8
`define OPR_CF_VAR_HI 4
`define OPR_CF_VAR_LO 0
`define OPR_CFG_MASK 24'h00c71f
// oscillator control register fields
`define OPR_CT_CUR_LO 12
`define OPR_CT_REQ_LO 8
`define OPR_CT_CF 3
`define OPR_CT_SWR 0
// reset cause and event bits
`define OPR_C_POR 0
`define OPR_C_EXTRUN 1
`define OPR_C_EXTSLP 2
`define OPR_C_WDT 3
`define OPR_C_BOR 4
`define OPR_C_SWR 5
`define OPR_C_TRAP 6
`define OPR_C_IOP 7
`define OPR_C_CLKF 8
`define OPR_NCAUSE 9
// timing
`define OPR_CLK_NS 40
`define OPR_BIAS_US 10
`define OPR_FILT_CYC 8
`define OPR_LF_KHZ 32
`define OPR_POWER_UP_TIMER_MS1 4
`define OPR_POWER_UP_TIMER_MS2 16
`define OPR_POWER_UP_TIMER_MS3 64
`endif

/* hdl/opr_pkg.sv */
/*
  Types of the oscillator configuration and power-on reset sequencer.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package opr_pkg;
  // oscillator groups
  typedef enum logic [2:0] {
    GRP_LPXTAL = 3'h0,
    GRP_FRC = 3'h1,
    GRP_LOW_POWER_INTERNAL_RC = 3'h2,
    GRP_EXT = 3'h3,
    GRP_PLL = 3'h7
  } opr_group_t;
  // sequencer states, gray along the power-up path
  typedef enum logic [2:0] {
    ST_HOLD = 3'h0,
    ST_BIAS = 3'h1,
    ST_POWER_UP_TIMER = 3'h3,
    ST_ALIGN = 3'h2,
    ST_RUN = 3'h6
  } opr_state_t;
  // decoded clock selection handed to the clock tree
  typedef struct packed {
    logic switch_en;
    logic monitor_en;
    logic [2:0] group;
    logic [4:0] variant;
  } opr_clk_sel_t;
endpackage : opr_pkg

/* hdl/opr_sequencer.sv */
/*
  Oscillator tuning/configuration registers and the reset sequencer,
  with a classic Wishbone slave and a level interrupt.
  Assumes all inputs synchronous to clk_i, lf_tick_i a one-cycle strobe
  of the free-running low-frequency clock, and supply/brown-out inputs
  as one-cycle pulses from the analog detectors.
*/
// Our own choices: the register addresses and the Wishbone interface to the registers.
// Functional notes
// - four-bit tuning field, upper bits read zero
// - tuning is signed offset, zero is centre
// - config bits 15:14 gate switching and monitor
// - config bits 10:8 pick start-up group
// - config bits 4:0 pick primary variant
// - config word readable, unused bits zero
// - every reset cause recorded in status bits
// - watchdog wake-up resumes, no reset
// - external pin filtered against short pulses
// - internal resets never drive pin low
// - supply rise restarts timer, holds reset
// - bias delay then selectable power-up delay
// - release reset on first instruction phase
// - monitor traps bad clock, selects fast RC
// - no delay, no monitor: quick exit
// - no monitor, no clock: stay frozen
// - power events load current/requested groups
// - clock fail: group, flag, clear request
`timescale 1ns/1ns
`include "opr_cfg.svh"
module opr_sequencer #(
  parameter int FILT_CYC = `OPR_FILT_CYC,
  parameter int LF_KHZ = `OPR_LF_KHZ
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic supply_rise_i,
  input wire logic brown_out_i,
  input wire logic ext_reset_pin_n_i,
  input wire logic wdt_timeout_i,
  input wire logic wdt_wake_i,
  input wire logic reset_instr_i,
  input wire logic trap_lockup_i,
  input wire logic illegal_op_i,
  input wire logic sleep_i,
  input wire logic [23:0] config_word_i,
  input wire logic [1:0] power_up_sel_i,
  input wire logic lf_tick_i,
  input wire logic osc_running_i,
  input wire logic ost_done_i,
  input wire logic pll_lock_i,
  output logic sys_reset_o,
  output logic clock_fail_trap_o,
  output logic ext_reset_pin_o,
  output logic ext_reset_pin_oe_o,
  output opr_pkg::opr_clk_sel_t clk_sel_o,
  output logic signed [3:0] tuning_offset_o,
  output logic irq_o
);
  import opr_pkg::*;

  ////////////////////////////////////////////////////////////////////
  // constants

  localparam int CNT_W = 16; // delay counter width
  localparam int NC = `OPR_NCAUSE; // cause bits
  // bias settle, least time so rounded up
  localparam int BIAS_CYC =
    (`OPR_BIAS_US * 1000 + `OPR_CLK_NS - 1) / `OPR_CLK_NS;
  localparam logic [CNT_W-1:0] BIAS_LAST = CNT_W'(BIAS_CYC - 1);

  ////////////////////////////////////////////////////////////////////
  // functions

  // config word to clock selection
  function automatic opr_clk_sel_t dec_cfg(input logic [23:0] w);
    opr_clk_sel_t s;
    s.switch_en = !w[`OPR_CF_SWM_HI]; // 1x disables both
    s.monitor_en = !w[`OPR_CF_SWM_HI] && !w[`OPR_CF_SWM_LO];
    s.group = w[`OPR_CF_GRP_HI:`OPR_CF_GRP_LO];
    s.variant = w[`OPR_CF_VAR_HI:`OPR_CF_VAR_LO];
    return s;
  endfunction : dec_cfg

  // power-up delay in low-frequency ticks
  function automatic logic [CNT_W-1:0] power_up_timer_ticks(input logic [1:0] s);
    unique case (s)
      2'h0: power_up_timer_ticks = '0;
      2'h1: power_up_timer_ticks = CNT_W'(`OPR_POWER_UP_TIMER_MS1 * LF_KHZ);
      2'h2: power_up_timer_ticks = CNT_W'(`OPR_POWER_UP_TIMER_MS2 * LF_KHZ);
      2'h3: power_up_timer_ticks = CNT_W'(`OPR_POWER_UP_TIMER_MS3 * LF_KHZ);
    endcase
  endfunction : power_up_timer_ticks

  ////////////////////////////////////////////////////////////////////
  // state

  opr_state_t state; // sequencer state
  opr_state_t next_state;
  logic [CNT_W-1:0] cnt; // bias cycles or power-up ticks
  logic [1:0] phase; // instruction clock phase, 0 = first
  logic [7:0] filt_cnt; // low time of the external pin
  logic ext_filt; // filtered external reset
  logic [3:0] tune; // tuning field
  logic [2:0] cur_grp; // current group
  logic [2:0] req_grp; // requested group
  logic clk_fail; // clock fail flag
  logic sw_req; // switch request
  logic [NC-1:0] status; // sticky causes, write one to clear
  logic [NC-1:0] mask; // interrupt mask
  opr_clk_sel_t cfg; // decoded configuration

  assign cfg = dec_cfg(config_word_i);

  ////////////////////////////////////////////////////////////////////
  // bus decode

  wire req = wb_cyc_i && wb_stb_i && !wb_ack_o; // new access
  wire wr = req && wb_we_i;
  wire hit_tune = wb_adr_i == `OPR_ADR_TUNE;
  wire hit_cfg = wb_adr_i == `OPR_ADR_CFG;
  wire hit_ctrl = wb_adr_i == `OPR_ADR_CTRL;
  wire hit_stat = wb_adr_i == `OPR_ADR_STAT;
  wire hit_mask = wb_adr_i == `OPR_ADR_MASK;
  wire wr_lo = wr && wb_sel_i[0]; // byte lane 0
  wire wr_hi = wr && wb_sel_i[1]; // byte lane 1
  // status clear vector, lane-gated
  wire [NC-1:0] stat_clr = {wr_hi, {(NC-1){wr_lo}}}
    & wb_dat_i[NC-1:0] & {NC{hit_stat}};
  wire [NC-1:0] mask_wm = {wr_hi, {(NC-1){wr_lo}}} & {NC{hit_mask}};

  // control word as read
  wire [31:0] ctrl_rd = (32'(cur_grp) << `OPR_CT_CUR_LO)
    | (32'(req_grp) << `OPR_CT_REQ_LO)
    | (32'(clk_fail) << `OPR_CT_CF)
    | (32'(sw_req) << `OPR_CT_SWR);

  // read mux; unmapped offsets read zero
  wire [31:0] rd_data =
    hit_tune ? {28'h0, tune} :
    hit_cfg ? {8'h0, config_word_i & `OPR_CFG_MASK} :
    hit_ctrl ? ctrl_rd :
    hit_stat ? 32'(status) :
    hit_mask ? 32'(mask) : 32'h0;

  ////////////////////////////////////////////////////////////////////
  // reset events

  wire pwr_evt = supply_rise_i || brown_out_i; // cold start
  // warm resets; a watchdog wake-up is not one
  wire warm_evt = ext_filt || wdt_timeout_i || reset_instr_i
    || trap_lockup_i || illegal_op_i;
  wire [CNT_W-1:0] pw_target = power_up_timer_ticks(power_up_sel_i);
  wire bias_done = cnt == BIAS_LAST;
  wire power_up_timer_done = lf_tick_i && cnt == pw_target - 1'b1;
  // monitor lets the trap supply the clock, else wait
  wire clk_ok = osc_running_i || cfg.monitor_en;
  wire release_now = state == ST_ALIGN && phase == 2'h0 && clk_ok;
  // source not ready when the delays expire
  wire ost_grp = cur_grp == GRP_EXT || cur_grp == GRP_LPXTAL;
  wire clk_bad = !osc_running_i || (ost_grp && !ost_done_i)
    || (cur_grp == GRP_PLL && !pll_lock_i);
  wire fail_now = cfg.monitor_en && !pwr_evt && cur_grp != GRP_FRC
    && ((release_now && clk_bad)
    || (state == ST_RUN && !osc_running_i));
  // switch completes when switching is allowed
  wire sw_done = sw_req && cfg.switch_en && !fail_now;

  // cause capture
  logic [NC-1:0] set_vec;
  always_comb begin
    set_vec = '0;
    set_vec[`OPR_C_POR] = supply_rise_i;
    set_vec[`OPR_C_BOR] = pwr_evt;
    set_vec[`OPR_C_EXTRUN] = ext_filt && !sleep_i;
    set_vec[`OPR_C_EXTSLP] = ext_filt && sleep_i;
    set_vec[`OPR_C_WDT] = wdt_timeout_i || (wdt_wake_i && sleep_i);
    set_vec[`OPR_C_SWR] = reset_instr_i;
    set_vec[`OPR_C_TRAP] = trap_lockup_i;
    set_vec[`OPR_C_IOP] = illegal_op_i;
    set_vec[`OPR_C_CLKF] = fail_now;
  end
  // set wins over clear
  wire [NC-1:0] next_status = (status & ~stat_clr) | set_vec;

  ////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    next_state = state;
    if (pwr_evt) begin
      next_state = ST_BIAS; // restart the timer
    end else if (warm_evt) begin
      next_state = ST_HOLD; // held while the source stands
    end else begin
      unique case (state)
        ST_HOLD: next_state = ST_ALIGN;
        ST_BIAS: begin
          // zero delay skips straight on
          if (bias_done) begin
            next_state = pw_target == '0 ? ST_ALIGN : ST_POWER_UP_TIMER;
          end
        end
        ST_POWER_UP_TIMER: begin
          if (power_up_timer_done) begin
            next_state = ST_ALIGN;
          end
        end
        ST_ALIGN: begin
          if (release_now) begin
            next_state = ST_RUN;
          end
        end
        ST_RUN: next_state = ST_RUN;
        default: next_state = ST_HOLD; // illegal code
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////
  // sequencer registers

  // state and delay counter
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state <= ST_BIAS;
      cnt <= '0;
      sys_reset_o <= 1'b1;
    end else if (ce_i) begin
      state <= next_state;
      sys_reset_o <= next_state != ST_RUN;
      if (next_state != state || pwr_evt) begin
        cnt <= '0;
      end else if (state == ST_BIAS) begin
        cnt <= cnt + 1'b1;
      end else if (state == ST_POWER_UP_TIMER && lf_tick_i) begin
        cnt <= cnt + 1'b1; // independent of system clock
      end
    end
  end

  // instruction clock phase, free running
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      phase <= 2'h0;
    end else if (ce_i) begin
      phase <= phase + 2'h1;
    end
  end

  // pin filter: low must last FILT_CYC cycles
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      filt_cnt <= 8'h0;
      ext_filt <= 1'b0;
    end else if (ce_i) begin
      if (ext_reset_pin_n_i) begin
        filt_cnt <= 8'h0;
        ext_filt <= 1'b0;
      end else if (filt_cnt == 8'(FILT_CYC - 1)) begin
        ext_filt <= 1'b1;
      end else begin
        filt_cnt <= filt_cnt + 8'h1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // oscillator control

  // groups, fail flag and switch request
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cur_grp <= GRP_FRC;
      req_grp <= GRP_FRC;
      clk_fail <= 1'b0;
      sw_req <= 1'b0;
    end else if (ce_i) begin
      if (pwr_evt) begin
        cur_grp <= cfg.group;
        req_grp <= cfg.group;
        clk_fail <= 1'b0;
        sw_req <= 1'b0;
      end else if (fail_now) begin
        // group, flag, request all land on one edge
        cur_grp <= GRP_FRC;
        clk_fail <= 1'b1;
        sw_req <= 1'b0;
      end else begin
        if (wr_hi && hit_ctrl) begin
          req_grp <= wb_dat_i[`OPR_CT_REQ_LO +: 3];
        end
        if (wr_lo && hit_ctrl) begin
          sw_req <= wb_dat_i[`OPR_CT_SWR];
          clk_fail <= clk_fail && wb_dat_i[`OPR_CT_CF];
        end else if (sw_done || sw_req) begin
          sw_req <= 1'b0; // done, or refused when disabled
        end
        if (sw_done) begin
          cur_grp <= req_grp;
        end
      end
    end
  end

  // tuning register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tune <= `OPR_TUNE_RST;
    end else if (ce_i && wr_lo && hit_tune) begin
      tune <= wb_dat_i[`OPR_TUNE_W-1:0];
    end
  end

  // outputs to the clock tree
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tuning_offset_o <= 4'sh0;
      clk_sel_o <= '0;
      clock_fail_trap_o <= 1'b0;
      ext_reset_pin_o <= 1'b0;
      ext_reset_pin_oe_o <= 1'b0;
    end else if (ce_i) begin
      tuning_offset_o <= signed'(tune);
      clk_sel_o <= '{switch_en: cfg.switch_en,
        monitor_en: cfg.monitor_en,
        group: fail_now ? GRP_FRC : (pwr_evt ? cfg.group : cur_grp),
        variant: cfg.variant};
      clock_fail_trap_o <= fail_now;
      ext_reset_pin_o <= 1'b0; // pin is input only
      ext_reset_pin_oe_o <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // status, mask, interrupt and bus answer

  // sticky causes and mask
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      status <= '0;
      mask <= '0;
      irq_o <= 1'b0;
    end else if (ce_i) begin
      status <= next_status;
      mask <= (mask & ~mask_wm) | (wb_dat_i[NC-1:0] & mask_wm);
      irq_o <= |(next_status & mask);
    end
  end

  // one wait state, ack drops the cycle after
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0;
    end else if (ce_i) begin
      wb_ack_o <= req;
      wb_dat_o <= req ? rd_data : 32'h0;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // assertions

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_tune_read_zero: assert property (
    wb_ack_o && !wb_we_i && hit_tune |-> wb_dat_o[31:4] == 28'h0)
    else $error("tuning upper bits not zero");
  a_tune_offset_out: assert property (
    ce_i && wr_lo && hit_tune ##1 ce_i |=>
    tuning_offset_o == signed'($past(wb_dat_i[3:0], 2)))
    else $error("tuning offset not passed on");
  a_cfg_unused_zero: assert property (
    wb_ack_o && !wb_we_i && hit_cfg |->
    wb_dat_o[31:16] == 16'h0 && wb_dat_o[13:11] == 3'h0
    && wb_dat_o[7:5] == 3'h0)
    else $error("config unused bits not zero");
  a_pin_not_driven: assert property (
    !ext_reset_pin_oe_o && !ext_reset_pin_o)
    else $error("reset pin driven");
  a_filter_short: assert property (
    ce_i && $fell(ext_reset_pin_n_i) |-> !ext_filt ##1 !ext_filt)
    else $error("short pin pulse passed filter");
  a_por_restart: assert property (
    ce_i && supply_rise_i |=> state == ST_BIAS && cnt == '0
    && sys_reset_o)
    else $error("supply rise did not restart");
  a_bias_length: assert property (
    ce_i && state == ST_BIAS && next_state != ST_BIAS && !pwr_evt
    && !warm_evt |-> cnt == BIAS_LAST)
    else $error("bias delay length wrong");
  a_release_phase: assert property (
    $fell(sys_reset_o) |-> $past(phase) == 2'h0)
    else $error("reset released off first phase");
  a_fail_switch: assert property (
    clock_fail_trap_o |-> cur_grp == GRP_FRC && clk_fail && !sw_req
    && clk_sel_o.group == GRP_FRC && status[`OPR_C_CLKF])
    else $error("clock fail did not switch");
  a_por_groups: assert property (
    ce_i && supply_rise_i |=> cur_grp == $past(cfg.group)
    && req_grp == $past(cfg.group))
    else $error("groups not loaded on power event");
  a_frozen_hold: assert property (
    state == ST_ALIGN && !cfg.monitor_en && !osc_running_i |=>
    sys_reset_o)
    else $error("left reset without clock");
  a_wake_resume: assert property (
    ce_i && state == ST_RUN && wdt_wake_i && !pwr_evt && !warm_evt
    |=> state == ST_RUN && !sys_reset_o)
    else $error("watchdog wake reset the device");
endmodule : opr_sequencer

/* sim/opr_partner.sv */
/*
  model of the supply rise detector, the external reset pin and the
  free-running slow clock. assumes its tasks are called from the bench
  process, on the same clk_i.
*/
`timescale 1ns/1ns
module opr_partner #(
  parameter int TICK_DIV = 4
) (
  input wire logic clk_i,
  output logic supply_rise_o,
  output logic ext_reset_pin_n_o,
  output logic lf_tick_o
);
  int div = 0; // slow clock divider
  ////////////////////////////////////////////////////////////////
  initial begin
    supply_rise_o = 1'b0;
    ext_reset_pin_n_o = 1'b1;
    lf_tick_o = 1'b0;
  end
  // slow clock runs free, whatever clock the system picked
  always @(posedge clk_i) begin
    div <= (div == TICK_DIV - 1) ? 0 : div + 1;
    lf_tick_o <= (div == TICK_DIV - 1);
  end
  ////////////////////////////////////////////////////////////////
  // one-cycle supply rise pulse
  task automatic power_up();
    @(posedge clk_i);
    supply_rise_o <= 1'b1;
    @(posedge clk_i);
    supply_rise_o <= 1'b0;
  endtask : power_up
  // pin pulled low n cycles; the pull-up brings it back high
  task automatic pin_low(input int n);
    @(posedge clk_i);
    ext_reset_pin_n_o <= 1'b0;
    repeat (n) @(posedge clk_i);
    ext_reset_pin_n_o <= 1'b1;
  endtask : pin_low
endmodule : opr_partner

/* sim/tb_top.sv */
/*
  self-checking bench of the oscillator configuration and reset
  sequencer. assumes the header, package and design compile first.
*/
`timescale 1ns/1ns
`include "opr_cfg.svh"
module tb_top;
  import opr_pkg::*;
  localparam int FILT = 4; // short pin filter
  localparam int DIV = 4; // system cycles per slow tick
  localparam int BIAS = `OPR_BIAS_US * 1000 / `OPR_CLK_NS;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] dat = 32'h0;
  logic [31:0] q; // last read data
  logic [3:0] warm = 4'h0; // wdt, instr, trap, illegal
  logic wake = 1'b0;
  logic bo = 1'b0; // brown-out pulse
  logic sleep = 1'b0;
  logic [23:0] cfg = 24'h00c100;
  logic [1:0] psel = 2'h0;
  logic osc = 1'b1;
  logic pll = 1'b1;
  logic seen = 1'b0; // sticky: reset seen
  logic sup, pin_n, tick, sys_rst, trap, pin_o, pin_oe, irq, ack;
  logic [31:0] rdat;
  opr_clk_sel_t sel_o;
  logic signed [3:0] tune_o;
  int failures = 0;
  int cmp_count = 0;
  int cycles = 0;
  int seed = 32'hdc7f;
  logic [31:0] d;
  opr_group_t grps [5] = '{GRP_PLL, GRP_EXT, GRP_LOW_POWER_INTERNAL_RC, GRP_FRC,
    GRP_LPXTAL};
  ////////////////////////////////////////////////////////////////
  opr_sequencer #(.FILT_CYC(FILT), .LF_KHZ(1)) u_dut (
    .clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf),
    .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .supply_rise_i(sup), .brown_out_i(bo),
    .ext_reset_pin_n_i(pin_n), .wdt_timeout_i(warm[0]),
    .wdt_wake_i(wake), .reset_instr_i(warm[1]),
    .trap_lockup_i(warm[2]), .illegal_op_i(warm[3]), .sleep_i(sleep),
    .config_word_i(cfg), .power_up_sel_i(psel), .lf_tick_i(tick),
    .osc_running_i(osc), .ost_done_i(osc), .pll_lock_i(pll),
    .sys_reset_o(sys_rst), .clock_fail_trap_o(trap),
    .ext_reset_pin_o(pin_o), .ext_reset_pin_oe_o(pin_oe),
    .clk_sel_o(sel_o), .tuning_offset_o(tune_o), .irq_o(irq));
  opr_partner #(.TICK_DIV(DIV)) u_partner (
    .clk_i(clk_i), .supply_rise_o(sup), .ext_reset_pin_n_o(pin_n),
    .lf_tick_o(tick));
  ////////////////////////////////////////////////////////////////
  always #20 clk_i = ~clk_i;
  // hang guard, far above the run length
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      failures++;
      stop_test();
    end
  end
  // sticky record of any system reset
  always @(posedge clk_i) if (sys_rst === 1'b1) seen <= 1'b1;
  ////////////////////////////////////////////////////////////////
  task automatic stop_test();
    if (failures == 0 && cmp_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : stop_test
  task automatic chk(input string nm, input logic [31:0] e,
      input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      failures++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // one classic cycle; answer latency never assumed
  task automatic wb(input logic w, input logic [7:0] a,
      input logic [31:0] v);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= v;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 40);
    chk("wb_ack", 1'b1, ack);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask : wb
  // slow ticks of the power-up delay for a select code
  function automatic int ticks(input logic [1:0] s);
    return (s == 2'h0) ? 0 : (s == 2'h1) ? `OPR_POWER_UP_TIMER_MS1 :
      (s == 2'h2) ? `OPR_POWER_UP_TIMER_MS2 : `OPR_POWER_UP_TIMER_MS3;
  endfunction : ticks
  // power event, timed release, then config and cause checks
  task automatic pwr(input logic [23:0] c, input logic [1:0] s,
      input logic slow);
    int n, lo, hi;
    n = 0;
    lo = slow ? 600 : BIAS + ticks(s) * DIV - DIV;
    hi = slow ? 608 : BIAS + ticks(s) * DIV + 12;
    cfg <= c;
    psel <= s;
    osc <= !slow;
    u_partner.power_up();
    do begin
      @(posedge clk_i);
      n++;
      if (slow && n == 600) osc <= 1'b1;
    end while (sys_rst !== 1'b0 && n < 2000);
    chk("reset_cycles", (n < lo) ? lo : (n > hi) ? hi : n, n);
    wb(0, `OPR_ADR_CFG, 32'h0);
    chk("config_word", {8'h00, c & 24'h00c71f}, q);
    wb(0, `OPR_ADR_CTRL, 32'h0);
    chk("requested_group", {21'h0, c[10:8], 8'h0}, q & 32'h700);
    chk("clk_sel", {~c[15], c[15:14] == 2'b00, 3'h0, c[4:0]},
      {sel_o.switch_en, sel_o.monitor_en, 3'h0, sel_o.variant});
    wb(0, `OPR_ADR_STAT, 32'h0);
    chk("status_power", 32'h11, q & 32'h11);
    wb(1, `OPR_ADR_STAT, 32'h1ff);
  endtask : pwr
  ////////////////////////////////////////////////////////////////
  initial begin
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(0, `OPR_ADR_TUNE, 32'h0);
    chk("tune_reset", 32'h0, q);
    // corner codes first, then random
    for (int i = 0; i < 6; i++) begin
      d = (i == 0) ? 32'h7 : (i == 1) ? 32'hfffffff8 : $random(seed);
      wb(1, `OPR_ADR_TUNE, d);
      wb(0, `OPR_ADR_TUNE, 32'h0);
      chk("tune_read", {28'h0, d[3:0]}, q);
      chk("tuning_offset", {28'h0, d[3:0]}, {28'h0, tune_o});
    end
    for (int s = 0; s < 4; s++) begin
      pwr(24'h00c100 | ($random(seed) & 24'h1f), s[1:0], 1'b0);
    end
    // each group once, switch/monitor codes 10, 01, 00 in turn
    for (int i = 0; i < 5; i++) begin
      pwr({8'h00, (i % 3 == 0) ? 2'b10 : (i % 3 == 1) ? 2'b01 : 2'b00,
        3'h0, grps[i], 3'h0, 5'(i * 7)}, 2'h0, 1'b0);
      wb(0, `OPR_ADR_CTRL, 32'h0);
      chk("current_group", {17'h0, grps[i], 12'h0}, q & 32'h7000);
      chk("sel_group", {29'h0, grps[i]}, {29'h0, sel_o.group});
    end
    pwr(24'h00c300, 2'h0, 1'b1);
    wb(1, `OPR_ADR_CFG, 32'hffffffff);
    wb(0, `OPR_ADR_CFG, 32'h0);
    chk("config_ro", 32'h0000c300, q);
    wb(0, 8'h14, 32'h0);
    chk("unmapped", 32'h0, q);
    // pin filter: short pulse lost, long pulse resets
    seen <= 1'b0;
    u_partner.pin_low(FILT - 1);
    repeat (12) @(posedge clk_i);
    chk("short_pin", 1'b0, seen);
    u_partner.pin_low(FILT + 2);
    repeat (12) @(posedge clk_i);
    chk("long_pin", 1'b1, seen);
    wb(0, `OPR_ADR_STAT, 32'h0);
    chk("pin_run_cause", 32'h2, q & 32'h6);
    wb(1, `OPR_ADR_STAT, 32'h1ff);
    sleep <= 1'b1;
    u_partner.pin_low(FILT + 2);
    repeat (12) @(posedge clk_i);
    wb(0, `OPR_ADR_STAT, 32'h0);
    chk("pin_sleep_cause", 32'h4, q & 32'h6);
    wb(1, `OPR_ADR_STAT, 32'h1ff);
    // watchdog wake resumes, registers kept
    seen <= 1'b0;
    wake <= 1'b1;
    @(posedge clk_i);
    wake <= 1'b0;
    repeat (12) @(posedge clk_i);
    chk("wake_no_reset", 1'b0, seen);
    sleep <= 1'b0;
    wb(0, `OPR_ADR_STAT, 32'h0);
    chk("wake_cause", 32'h8, q & 32'h1ff);
    wb(0, `OPR_ADR_TUNE, 32'h0);
    chk("tune_kept", {28'h0, d[3:0]}, q);
    wb(1, `OPR_ADR_STAT, 32'h1ff);
    // warm resets, with interrupt raise, mask and clear
    wb(1, `OPR_ADR_MASK, 32'h1ff);
    for (int i = 0; i < 4; i++) begin
      seen <= 1'b0;
      warm <= 4'h1 << i;
      @(posedge clk_i);
      warm <= 4'h0;
      repeat (12) @(posedge clk_i);
      chk("warm_reset", 1'b1, seen);
      chk("warm_release", 1'b0, sys_rst);
      wb(0, `OPR_ADR_STAT, 32'h0);
      chk("warm_cause", 32'h1 << ((i == 0) ? 3 : i + 4), q);
      chk("irq_set", 1'b1, irq);
      wb(1, `OPR_ADR_MASK, 32'h0);
      wb(0, `OPR_ADR_TUNE, 32'h0);
      chk("irq_masked", 1'b0, irq);
      wb(1, `OPR_ADR_MASK, 32'h1ff);
      wb(1, `OPR_ADR_STAT, 32'h1ff);
      wb(0, `OPR_ADR_TUNE, 32'h0);
      chk("irq_clear", 1'b0, irq);
    end
    chk("pin_drive", 2'b00, {pin_oe, pin_o});
    // monitor catches a clock lost while running
    pwr(24'h000300, 2'h0, 1'b0);
    osc <= 1'b0;
    for (int n = 0; n < 20 && trap !== 1'b1; n++) @(posedge clk_i);
    chk("fail_trap", 1'b1, trap);
    osc <= 1'b1;
    wb(0, `OPR_ADR_CTRL, 32'h0);
    chk("ctrl_after_fail", 32'h1308, q & 32'h7709);
    chk("fail_group", {29'h0, GRP_FRC}, {29'h0, sel_o.group});
    wb(0, `OPR_ADR_STAT, 32'h0);
    chk("fail_status", 32'h100, q & 32'h100);
    // unlocked pll at release falls back to fast rc
    pll <= 1'b0;
    pwr(24'h000700, 2'h0, 1'b0);
    chk("pll_fail_group", {29'h0, GRP_FRC}, {29'h0, sel_o.group});
    pll <= 1'b1;
    // brown-out alone: its own cause bit, groups reloaded
    bo <= 1'b1;
    @(posedge clk_i);
    bo <= 1'b0;
    repeat (300) @(posedge clk_i);
    wb(0, `OPR_ADR_STAT, 32'h0);
    chk("bor_cause", 32'h10, q & 32'h11);
    wb(0, `OPR_ADR_CTRL, 32'h0);
    chk("bor_groups", 32'h7700, q & 32'h7700);
    stop_test();
  end
endmodule : tb_top
